// *** src/observe_output.sv ***
// Observation output register bank with its serial register port.
// Assumes serial pins arrive asynchronously and internal sources
// and tuning status come from logic on mclk_i.
//
// How it works
// - Five-bit selector, resets to one
// - Code zero outputs test data bit
// - Codes 1-3: lock signals
// - Code 4 ring osc; 5 high; 6 low
// - Codes 8-12: reference, divider, mod and aux clocks
// - Codes 13-17: aux port, phase detector
// - Codes 18-22: modulator clocks, strobes
// - Codes 23-25: latch, reset, seed
// - Code 30 buffer enable; 31 soft reset
// - Automux shares pin unless prevented
// - Pull-up disable stops high drive
// - Pull-down disable stops low drive
// - Read-only eight-bit tuning curve code
// - Zero highest frequency, ones lowest
// - Read-only busy flag, resets zero
`timescale 1ns/1ps
module observe_output
    import observe_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_enable_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    input wire logic [7:0] tune_curve_i,
    input wire logic tune_busy_i,
    input wire logic lock_i,
    input wire logic lock_trigger_i,
    input wire logic lock_window_i,
    input wire logic ring_osc_i,
    input wire logic ref_buffer_i,
    input wire logic ref_divider_i,
    input wire logic osc_divider_i,
    input wire logic mod_clock_i,
    input wire logic aux_clock_i,
    input wire logic aux_serial_clock_i,
    input wire logic aux_serial_enable_i,
    input wire logic aux_serial_data_i,
    input wire logic phase_detector_down_pulse_i,
    input wire logic phase_detector_up_pulse_i,
    input wire logic mod_delay_clock_i,
    input wire logic third_order_modulator_clock_i,
    input wire logic int_strobe_i,
    input wire logic frac_strobe_a_i,
    input wire logic frac_strobe_b_i,
    input wire logic divider_reset_i,
    input wire logic seed_load_i,
    input wire logic software_reset_low_i
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sck_sync;
    logic [1:0] sen_sync;
    logic [1:0] sdi_sync;
    logic sck_last;

    // Clock pin plus one stage for edge detection
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sck_sync <= 2'b00;
            sck_last <= 1'b0;
        end else begin
            sck_sync <= {sck_sync[0], serial_clock_i};
            sck_last <= sck_sync[1];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sen_sync <= 2'b00;
        end else begin
            sen_sync <= {sen_sync[0], serial_enable_i};
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sdi_sync <= 2'b00;
        end else begin
            sdi_sync <= {sdi_sync[0], serial_data_in_i};
        end
    end

    wire sck_rise = sck_sync[1] & ~sck_last;
    wire sen = sen_sync[1];
    wire sdi = sdi_sync[1];
    wire bit_strobe = sck_rise & sen;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] source_select;
    logic test_data;
    logic prevent_automux;
    logic pullup_disable;
    logic pulldown_disable;
    logic [7:0] tune_curve;
    logic tune_busy;

    // ------------------------------------------------------------
    // Serial frame state
    // ------------------------------------------------------------
    logic [FRAME_BITS-2:0] shift_in;
    logic [4:0] bit_count;
    logic [DATA_BITS-1:0] read_shift;
    logic read_phase;

    wire header_done = bit_strobe && (bit_count == HEADER_LAST_BIT);
    wire frame_done = bit_strobe && (bit_count == FRAME_LAST_BIT);
    wire header_read = shift_in[5];
    wire [ADDR_BITS-1:0] header_addr = {shift_in[4:0], sdi};
    wire frame_read = shift_in[FRAME_BITS-2];
    wire [ADDR_BITS-1:0] frame_addr = shift_in[28:23];
    wire [DATA_BITS-1:0] frame_data = {shift_in[22:0], sdi};

    wire write_select = frame_done && !frame_read
        && (frame_addr == OBSERVE_OUTPUT_SELECT_ADDR);

    // ------------------------------------------------------------
    // Read data decode
    // ------------------------------------------------------------
    function automatic logic [DATA_BITS-1:0] read_word(
        input logic [ADDR_BITS-1:0] addr
    );
        logic [DATA_BITS-1:0] word;
        word = '0;
        if (addr == OBSERVE_OUTPUT_SELECT_ADDR) begin
            word[SOURCE_SELECT_MSB:SOURCE_SELECT_LSB] = source_select;
            word[TEST_DATA_BIT] = test_data;
            word[PREVENT_AUTOMUX_BIT] = prevent_automux;
            word[PULLUP_DISABLE_BIT] = pullup_disable;
            word[PULLDOWN_DISABLE_BIT] = pulldown_disable;
        end else if (addr == TUNING_STATUS_ADDR) begin
            word[TUNE_CURVE_MSB:0] = tune_curve;
            word[TUNE_BUSY_BIT] = tune_busy;
        end
        return word;
    endfunction

    wire [DATA_BITS-1:0] header_word = read_word(header_addr);

    // ------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------
    logic [4:0] next_bit_count;
    assign next_bit_count = bit_count + 5'h01;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_in <= '0;
        end else if (bit_strobe) begin
            shift_in <= {shift_in[FRAME_BITS-3:0], sdi};
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_count <= 5'h00;
        end else if (!sen) begin
            bit_count <= 5'h00;
        end else if (bit_strobe) begin
            bit_count <= frame_done ? 5'h00 : next_bit_count;
        end
    end

    // Read phase runs from header end to frame end
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_phase <= 1'b0;
        end else if (!sen || frame_done) begin
            read_phase <= 1'b0;
        end else if (header_done) begin
            read_phase <= header_read;
        end
    end

    // Read data shifts out MSB first after the header
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_shift <= '0;
        end else if (header_done) begin
            read_shift <= header_word;
        end else if (bit_strobe && read_phase && !frame_done) begin
            read_shift <= {read_shift[DATA_BITS-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Selection register write
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            source_select <= SOURCE_SELECT_RESET;
        end else if (write_select) begin
            source_select <=
                frame_data[SOURCE_SELECT_MSB:SOURCE_SELECT_LSB];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            test_data <= 1'b0;
            prevent_automux <= 1'b0;
            pullup_disable <= 1'b0;
            pulldown_disable <= 1'b0;
        end else if (write_select) begin
            test_data <= frame_data[TEST_DATA_BIT];
            prevent_automux <= frame_data[PREVENT_AUTOMUX_BIT];
            pullup_disable <= frame_data[PULLUP_DISABLE_BIT];
            pulldown_disable <= frame_data[PULLDOWN_DISABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Tuning status capture
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tune_curve <= TUNE_CURVE_RESET;
        end else begin
            tune_curve <= tune_curve_i;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tune_busy <= TUNE_BUSY_RESET;
        end else begin
            tune_busy <= tune_busy_i;
        end
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    logic observe_value;

    observe_source_mux u_mux (
        .observe_source_select_i(source_select),
        .test_data_i(test_data),
        .lock_i(lock_i),
        .lock_trigger_i(lock_trigger_i),
        .lock_window_i(lock_window_i),
        .ring_osc_i(ring_osc_i),
        .ref_buffer_i(ref_buffer_i),
        .ref_divider_i(ref_divider_i),
        .osc_divider_i(osc_divider_i),
        .mod_clock_i(mod_clock_i),
        .aux_clock_i(aux_clock_i),
        .aux_serial_clock_i(aux_serial_clock_i),
        .aux_serial_enable_i(aux_serial_enable_i),
        .aux_serial_data_i(aux_serial_data_i),
        .phase_detector_down_pulse_i(phase_detector_down_pulse_i),
        .phase_detector_up_pulse_i(phase_detector_up_pulse_i),
        .mod_delay_clock_i(mod_delay_clock_i),
        .third_order_modulator_clock_i(third_order_modulator_clock_i),
        .int_strobe_i(int_strobe_i),
        .frac_strobe_a_i(frac_strobe_a_i),
        .frac_strobe_b_i(frac_strobe_b_i),
        .latch_enable_i(sen),
        .divider_reset_i(divider_reset_i),
        .seed_load_i(seed_load_i),
        .out_buffer_en_i(read_phase),
        .software_reset_low_i(software_reset_low_i),
        .observe_output_o(observe_value)
    );

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Read data takes the pin during a read unless automux is prevented
    wire share_active = !prevent_automux && read_phase;
    wire next_pin_value = share_active ? read_shift[DATA_BITS-1]
        : observe_value;
    // No high drive with pull-up disabled
    // No low drive with pull-down disabled
    wire next_pin_enable = next_pin_value ? !pullup_disable
        : !pulldown_disable;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_data_out_o <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
        end else begin
            serial_data_out_o <= next_pin_value;
            serial_data_out_oe_o <= next_pin_enable;
        end
    end

endmodule

// *** src/observe_pkg.sv ***
// Constants shared by the observation output block and its source mux.
// Assumes one 100 MHz clock and a three-wire serial register port.
package observe_pkg;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 31;
    localparam int ADDR_BITS = 6;
    localparam int DATA_BITS = 24;
    localparam logic [4:0] HEADER_LAST_BIT = 5'h06;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h1e;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OBSERVE_OUTPUT_SELECT_ADDR = 6'h0f;
    localparam logic [5:0] TUNING_STATUS_ADDR = 6'h10;

    // ------------------------------------------------------------
    // Field positions, observe_output_select
    // ------------------------------------------------------------
    localparam int SOURCE_SELECT_LSB = 0;
    localparam int SOURCE_SELECT_MSB = 4;
    localparam int TEST_DATA_BIT = 5;
    localparam int PREVENT_AUTOMUX_BIT = 6;
    localparam int PULLUP_DISABLE_BIT = 8;
    localparam int PULLDOWN_DISABLE_BIT = 9;

    // ------------------------------------------------------------
    // Field positions, tuning_status
    // ------------------------------------------------------------
    localparam int TUNE_CURVE_MSB = 7;
    localparam int TUNE_BUSY_BIT = 8;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [4:0] SOURCE_SELECT_RESET = 5'h01;
    localparam logic [7:0] TUNE_CURVE_RESET = 8'h80;
    localparam logic TUNE_BUSY_RESET = 1'b0;

    // ------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        SRC_TEST_DATA = 5'b00000,
        SRC_LOCK = 5'b00001,
        SRC_LOCK_TRIGGER = 5'b00010,
        SRC_LOCK_WINDOW = 5'b00011,
        SRC_RING_OSC = 5'b00100,
        SRC_FORCE_HIGH = 5'b00101,
        SRC_FORCE_LOW = 5'b00110,
        SRC_REF_BUFFER = 5'b01000,
        SRC_REF_DIVIDER = 5'b01001,
        SRC_OSC_DIVIDER = 5'b01010,
        SRC_MOD_CLOCK = 5'b01011,
        SRC_AUX_CLOCK = 5'b01100,
        SRC_AUX_SERIAL_CLOCK = 5'b01101,
        SRC_AUX_SERIAL_ENABLE = 5'b01110,
        SRC_AUX_SERIAL_DATA = 5'b01111,
        SRC_PD_DOWN = 5'b10000,
        SRC_PHASE_DETECTOR_UP_PULSE = 5'b10001,
        SRC_MOD_DELAY_CLOCK = 5'b10010,
        SRC_MOD_CORE_CLOCK = 5'b10011,
        SRC_INT_STROBE = 5'b10100,
        SRC_FRAC_STROBE_A = 5'b10101,
        SRC_FRAC_STROBE_B = 5'b10110,
        SRC_LATCH_ENABLE = 5'b10111,
        SRC_DIVIDER_RESET = 5'b11000,
        SRC_SEED_LOAD = 5'b11001,
        SRC_OUT_BUFFER_EN = 5'b11110,
        SRC_SOFT_RESET = 5'b11111
    } observe_source_t;

endpackage

// *** src/observe_source_mux.sv ***
// Picks one internal signal by the five-bit source code.
// Assumes all sources are levels already on the block's clock.
`timescale 1ns/1ps
module observe_source_mux
    import observe_pkg::*;
(
    input wire logic [4:0] observe_source_select_i,
    input wire logic test_data_i,
    input wire logic lock_i,
    input wire logic lock_trigger_i,
    input wire logic lock_window_i,
    input wire logic ring_osc_i,
    input wire logic ref_buffer_i,
    input wire logic ref_divider_i,
    input wire logic osc_divider_i,
    input wire logic mod_clock_i,
    input wire logic aux_clock_i,
    input wire logic aux_serial_clock_i,
    input wire logic aux_serial_enable_i,
    input wire logic aux_serial_data_i,
    input wire logic phase_detector_down_pulse_i,
    input wire logic phase_detector_up_pulse_i,
    input wire logic mod_delay_clock_i,
    input wire logic third_order_modulator_clock_i,
    input wire logic int_strobe_i,
    input wire logic frac_strobe_a_i,
    input wire logic frac_strobe_b_i,
    input wire logic latch_enable_i,
    input wire logic divider_reset_i,
    input wire logic seed_load_i,
    input wire logic out_buffer_en_i,
    input wire logic software_reset_low_i,
    output logic observe_output_o
);

    // ------------------------------------------------------------
    // Source table, unused codes read low
    // ------------------------------------------------------------
    logic [31:0] sources;

    always_comb begin
        sources = 32'h0000_0000;
        sources[SRC_TEST_DATA] = test_data_i;
        sources[SRC_LOCK] = lock_i;
        sources[SRC_LOCK_TRIGGER] = lock_trigger_i;
        sources[SRC_LOCK_WINDOW] = lock_window_i;
        sources[SRC_RING_OSC] = ring_osc_i;
        sources[SRC_FORCE_HIGH] = 1'b1;
        sources[SRC_FORCE_LOW] = 1'b0;
        sources[SRC_REF_BUFFER] = ref_buffer_i;
        sources[SRC_REF_DIVIDER] = ref_divider_i;
        sources[SRC_OSC_DIVIDER] = osc_divider_i;
        sources[SRC_MOD_CLOCK] = mod_clock_i;
        sources[SRC_AUX_CLOCK] = aux_clock_i;
        sources[SRC_AUX_SERIAL_CLOCK] = aux_serial_clock_i;
        sources[SRC_AUX_SERIAL_ENABLE] = aux_serial_enable_i;
        sources[SRC_AUX_SERIAL_DATA] = aux_serial_data_i;
        sources[SRC_PD_DOWN] = phase_detector_down_pulse_i;
        sources[SRC_PHASE_DETECTOR_UP_PULSE] = phase_detector_up_pulse_i;
        sources[SRC_MOD_DELAY_CLOCK] = mod_delay_clock_i;
        sources[SRC_MOD_CORE_CLOCK] = third_order_modulator_clock_i;
        sources[SRC_INT_STROBE] = int_strobe_i;
        sources[SRC_FRAC_STROBE_A] = frac_strobe_a_i;
        sources[SRC_FRAC_STROBE_B] = frac_strobe_b_i;
        sources[SRC_LATCH_ENABLE] = latch_enable_i;
        sources[SRC_DIVIDER_RESET] = divider_reset_i;
        sources[SRC_SEED_LOAD] = seed_load_i;
        sources[SRC_OUT_BUFFER_EN] = out_buffer_en_i;
        sources[SRC_SOFT_RESET] = software_reset_low_i;
    end

    assign observe_output_o = sources[observe_source_select_i];

endmodule

// *** tb/observe_output_monitor.sv ***
// Checker for the observation pin, with its own small frame decoder.
// Assumes frames of read flag, address and data, MSB first.
`timescale 1ns/1ps
module observe_output_monitor
    import observe_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_enable_i,
    input wire logic serial_data_in_i,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_o,
    input wire logic lock_i,
    input wire logic ring_osc_i,
    input wire logic phase_detector_up_pulse_i
);
    logic sck_q, tst, pu, pd;
    logic [30:0] sh;
    logic [4:0] cnt, sel;
    logic [2:0] quiet;
    wire rise = serial_enable_i && serial_clock_i && !sck_q;
    wire take = !serial_enable_i && cnt == 5'h1f && !sh[30]
        && sh[29:24] == OBSERVE_OUTPUT_SELECT_ADDR;
    wire idle = quiet == 3'h7;
    wire out = serial_data_out_o;
    wire oe = serial_data_out_oe_o;

    // --------------------------------------------------------
    // Shadow of the select register
    // --------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sck_q <= 1'b0;
            sh <= '0;
            cnt <= 5'h00;
            quiet <= 3'h0;
            sel <= SOURCE_SELECT_RESET;
            tst <= 1'b0;
            pu <= 1'b0;
            pd <= 1'b0;
        end else begin
            sck_q <= serial_clock_i;
            if (rise) begin
                sh <= {sh[29:0], serial_data_in_i};
                cnt <= cnt + 5'h01;
            end else if (!serial_enable_i) begin
                cnt <= 5'h00;
            end
            quiet <= serial_enable_i ? 3'h0 : (idle ? quiet : quiet + 3'h1);
            if (take) begin
                sel <= sh[4:0];
                tst <= sh[5];
                pu <= sh[8];
                pd <= sh[9];
            end
        end
    end

    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_reset_idle; $rose(reset_n_i) |-> !out && !oe; endproperty
    property p_force_high; idle && sel == 5'h05 |-> out; endproperty
    property p_force_low; idle && sel == 5'h06 |-> !out; endproperty
    property p_test_data; idle && sel == 5'h00 |-> out == tst; endproperty
    property p_lock; idle && sel == 5'h01 |=> out == $past(lock_i);
    endproperty
    property p_ring;
        idle ##1 idle && sel == 5'h04 |-> out == $past(ring_osc_i);
    endproperty
    property p_phase_detector_up_pulse;
        idle && sel == 5'h11 |-> out == $past(phase_detector_up_pulse_i);
    endproperty
    property p_unused;
        idle && (sel == 5'h07 || sel inside {[5'h1a:5'h1d]}) |-> !out;
    endproperty
    property p_pullup; idle && out |-> oe == !pu; endproperty
    property p_pulldown; idle && !out |-> oe == !pd; endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("pin driven at reset release");
    a_force_high: assert property (p_force_high)
        else $error("code 5 not high");
    a_force_low: assert property (p_force_low)
        else $error("code 6 not low");
    a_test_data: assert property (p_test_data)
        else $error("code 0 not test data");
    a_lock: assert property (p_lock)
        else $error("code 1 not lock");
    a_ring: assert property (p_ring)
        else $error("code 4 not ring oscillator");
    a_phase_detector_up_pulse: assert property (p_phase_detector_up_pulse)
        else $error("code 17 not up pulse");
    a_unused: assert property (p_unused)
        else $error("unused code not low");
    a_pullup: assert property (p_pullup)
        else $error("high drive wrong");
    a_pulldown: assert property (p_pulldown)
        else $error("low drive wrong");
    c_test: cover property (idle && sel == 5'h00);
    c_take: cover property (take);
    c_soft: cover property (idle && sel == 5'h1f);
endmodule

// *** tb/serial_host_model.sv ***
// Serial host model that sends whole frames to the register port.
// Assumes calls start at a falling mclk edge; four mclk per phase.
`timescale 1ns/1ps
module serial_host_model (
    input wire logic mclk_i,
    input wire logic data_out_i,
    input wire logic data_out_oe_i,
    output logic serial_clock_o,
    output logic serial_enable_o,
    output logic serial_data_o
);
    initial begin
        serial_clock_o = 1'b0;
        serial_enable_o = 1'b0;
        serial_data_o = 1'b0;
    end

    task automatic xfer(input logic rd, input logic [5:0] addr,
            input logic [23:0] wdata, output logic [23:0] rdata);
        logic [30:0] frame;
        frame = {rd, addr, wdata};
        rdata = 24'h000000;
        serial_enable_o = 1'b1;
        for (int i = 30; i >= 0; i--) begin
            serial_data_o = frame[i];
            repeat (4) @(negedge mclk_i);
            if (i < 24) begin
                rdata = {rdata[22:0],
                    data_out_oe_i ? data_out_i : !data_out_i};
            end
            serial_clock_o = 1'b1;
            repeat (4) @(negedge mclk_i);
            serial_clock_o = 1'b0;
        end
        serial_enable_o = 1'b0;
        serial_data_o = !serial_data_o;
        repeat (8) @(negedge mclk_i);
    endtask
endmodule

// *** tb/tb.sv ***
// Testbench for the observation output block.
// Assumes the serial host model and the monitor beside it.
`timescale 1ns/1ps
module tb
    import observe_pkg::*;
;
    localparam logic [31:0] zero_codes = 32'h7c80_0080;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sclk, sen, sdi, sdo, sdo_oe, busy, rd_done, pin_probe, v;
    logic [7:0] curve;
    logic [31:0] src;
    logic [23:0] rd_val;
    logic [15:0] lfsr = 16'h7286;
    logic [15:0] r;
    logic [23:0] rq[$];
    logic [1:0] pq[$];
    int n_mismatch = 0;
    int check_count = 0;

    always #5 mclk_i = ~mclk_i;

    observe_output uut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .serial_clock_i(sclk), .serial_enable_i(sen),
        .serial_data_in_i(sdi), .serial_data_out_o(sdo),
        .serial_data_out_oe_o(sdo_oe), .tune_curve_i(curve),
        .tune_busy_i(busy), .lock_i(src[1]), .lock_trigger_i(src[2]),
        .lock_window_i(src[3]), .ring_osc_i(src[4]),
        .ref_buffer_i(src[8]), .ref_divider_i(src[9]),
        .osc_divider_i(src[10]), .mod_clock_i(src[11]),
        .aux_clock_i(src[12]), .aux_serial_clock_i(src[13]),
        .aux_serial_enable_i(src[14]), .aux_serial_data_i(src[15]),
        .phase_detector_down_pulse_i(src[16]),
        .phase_detector_up_pulse_i(src[17]),
        .mod_delay_clock_i(src[18]),
        .third_order_modulator_clock_i(src[19]),
        .int_strobe_i(src[20]), .frac_strobe_a_i(src[21]),
        .frac_strobe_b_i(src[22]), .divider_reset_i(src[24]),
        .seed_load_i(src[25]), .software_reset_low_i(src[31]));
    serial_host_model host (.mclk_i(mclk_i), .data_out_i(sdo),
        .data_out_oe_i(sdo_oe), .serial_clock_o(sclk),
        .serial_enable_o(sen), .serial_data_o(sdi));

    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    function logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    task automatic chk(input string n, input logic [23:0] e,
            input logic [23:0] s);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [23:0] e);
        logic [23:0] d;
        rq.push_back(e);
        host.xfer(1'b1, a, 24'h000000, d);
        rd_val = d;
        rd_done = 1'b1;
        @(negedge mclk_i);
        rd_done = 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        logic [23:0] x;
        host.xfer(1'b0, a, d, x);
    endtask
    task automatic pin(input logic [1:0] e);
        pq.push_back(e);
        pin_probe = 1'b1;
        @(negedge mclk_i);
        pin_probe = 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        if (rd_done === 1'b1) chk("read data", rq.pop_front(), rd_val);
        if (pin_probe === 1'b1) chk("pin", {22'h0, pq.pop_front()},
            {22'h0, sdo_oe, sdo});
    end

    initial begin
        repeat (100000) @(posedge mclk_i);
        n_mismatch++;
        $display("test watchdog expired");
        end_of_test();
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        src = 32'h0;
        curve = 8'h80;
        busy = 1'b0;
        rd_done = 1'b0;
        pin_probe = 1'b0;
        rd_val = 24'h000000;
        repeat (2) @(negedge mclk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rd(OBSERVE_OUTPUT_SELECT_ADDR, 24'h000001);
        rd(TUNING_STATUS_ADDR, 24'h000080);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            curve = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
            busy = (i == 1) | r[8];
            rd(TUNING_STATUS_ADDR, {15'h0, busy, curve});
        end
        $display("test status done");
        for (int c = 0; c < 32; c++) begin
            r = rnd();
            wr(OBSERVE_OUTPUT_SELECT_ADDR,
                {14'h0, r[2:1], 2'b01, r[0], c[4:0]});
            src = {rnd(), rnd()};
            repeat (2) @(negedge mclk_i);
            v = (c == 0) ? r[0] : (c == 5) ? 1'b1 : (c == 6) ? 1'b0
                : src[c] & ~zero_codes[c];
            pin({v ? !r[1] : !r[2], v});
        end
        $display("test source codes done");
        wr(OBSERVE_OUTPUT_SELECT_ADDR, 24'hfc00bf);
        rd(OBSERVE_OUTPUT_SELECT_ADDR, 24'h00003f);
        wr(OBSERVE_OUTPUT_SELECT_ADDR, 24'h000045);
        rd(TUNING_STATUS_ADDR, 24'hffffff);
        wr(OBSERVE_OUTPUT_SELECT_ADDR, 24'h000046);
        rd(TUNING_STATUS_ADDR, 24'h000000);
        wr(OBSERVE_OUTPUT_SELECT_ADDR, 24'h00005e);
        rd(TUNING_STATUS_ADDR, 24'hffffff);
        wr(OBSERVE_OUTPUT_SELECT_ADDR, 24'h000057);
        rd(TUNING_STATUS_ADDR, 24'hffffff);
        wr(OBSERVE_OUTPUT_SELECT_ADDR, 24'h000001);
        wr(TUNING_STATUS_ADDR, 24'h000000);
        rd(6'h20, 24'h000000);
        rd(TUNING_STATUS_ADDR, {15'h0, busy, curve});
        $display("test sharing and refusals done");
        end_of_test();
    end
endmodule

bind observe_output observe_output_monitor mon (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .serial_clock_i(serial_clock_i), .serial_enable_i(serial_enable_i),
    .serial_data_in_i(serial_data_in_i),
    .serial_data_out_o(serial_data_out_o),
    .serial_data_out_oe_o(serial_data_out_oe_o), .lock_i(lock_i),
    .ring_osc_i(ring_osc_i),
    .phase_detector_up_pulse_i(phase_detector_up_pulse_i));
